// [relay_bank_regs.svh]
// offsets, field positions, reset values and timing counts of the relay bank
// assumes byte offsets inside the card's A16 and A24/A32 windows
`ifndef RELAY_BANK_REGS_SVH
`define RELAY_BANK_REGS_SVH
// A16 configuration window: c000h + logical address * 40h
`define A16_CFG_TOP        2'h3
`define OFS_ID             8'h00
`define OFS_DEVTYPE        8'h02
`define OFS_CTRL           8'h04
`define OFS_MEM_BASE       8'h06
`define OFS_IRQ_LEVEL      8'h3e
// relay words on the main board and behind the expansion buffers
`define OFS_RELAY_FIRST    8'h40
`define OFS_RELAY_LAST     8'h4e
`define OFS_EXP_FIRST      8'h50
`define OFS_EXP_LAST       8'h5e
// control register fields
`define CTRL_MEM_EN_BIT    15
`define CTRL_COIL_RD_BIT   1
`define CTRL_CLEAR_BIT     0
// status fields read from the control offset
`define STAT_MODE_LSB      8
`define STAT_FIXED_BIT     3
`define STAT_EXP_BIT       2
// reset values
`define LA_DYNAMIC         8'hff
`define LA_NONE            8'h00
`define IRQ_LEVEL_RST      3'h0
`define CTRL_RST           16'h0000
`define MEM_BASE_RST       16'h0000
`define RELAY_RST          16'h0000
// timing
`define CLK_KHZ            40000
`define BUS_LED_ON_US      50000
`define BUS_LED_CYCLES     ((`BUS_LED_ON_US * `CLK_KHZ) / 1000)
`define EXP_WAIT_CYCLES    4
`endif

// [relay_bank_pkg.sv]
// types shared by the relay bank modules
// assumes the offsets and counts live in relay_bank_regs.svh
package relay_bank_pkg;

  typedef enum logic [4:0] {
    st_idle   = 5'b00001,
    st_decode = 5'b00010,
    st_exp    = 5'b00100,
    st_ack    = 5'b01000,
    st_wait   = 5'b10000
  } bus_state_type;

  typedef enum logic [4:0] {
    mode_single_2x64  = 5'b00001,
    mode_dual_2x32    = 5'b00010,
    mode_single_2x128 = 5'b00100,
    mode_dual_2x64    = 5'b01000,
    mode_quad_2x32    = 5'b10000
  } matrix_mode_type;

endpackage : relay_bank_pkg

// [relay_driver_word.sv]
// one relay driver element: 16-bit readable register, 16 coil drives,
// and a two-stage sampler of the coil levels for read-back
// assumes coil_level pins are asynchronous to ref_clk
`timescale 1ns/100ps
`include "relay_bank_regs.svh"
module relay_driver_word (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // register write
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_be,
  input  wire logic [15:0] wr_data,
  input  wire logic        clear,
  // coil side
  input  wire logic [15:0] coil_level,
  output logic      [15:0] coil_drive_r,
  output logic      [15:0] coil_seen_r
);

  logic [15:0] coil_meta_r;

  // a one energises the coil and closes the relay; each bit stands alone
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      coil_drive_r <= `RELAY_RST;
    end else if (clear) begin
      coil_drive_r <= `RELAY_RST;
    end else if (wr_en) begin
      if (wr_be[0]) coil_drive_r[7:0] <= wr_data[7:0];
      if (wr_be[1]) coil_drive_r[15:8] <= wr_data[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      coil_meta_r <= 16'h0000;
      coil_seen_r <= 16'h0000;
    end else begin
      coil_meta_r <= coil_level;
      coil_seen_r <= coil_meta_r;
    end
  end

  a_word_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_en && !clear && wr_be == 2'h3 |=> coil_drive_r == $past(wr_data))
    else $error("relay word did not take written value");

endmodule : relay_driver_word

// [activity_light.sv]
// front-panel activity light: lit for a fixed time after each access
// assumes trigger is a one-cycle pulse on ref_clk
`timescale 1ns/100ps
module activity_light #(
  parameter int unsigned ON_CYCLES = 2000000
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // trigger and lamp
  input  wire logic trigger,
  output logic      lamp_r
);

  logic [31:0] left_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      left_r <= 32'h0000_0000;
    end else if (trigger) begin
      left_r <= ON_CYCLES;
    end else if (left_r != 32'h0000_0000) begin
      left_r <= left_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lamp_r <= 1'b0;
    end else begin
      lamp_r <= trigger || (left_r > 32'h0000_0001);
    end
  end

  a_lamp_on_access: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trigger |=> lamp_r)
    else $error("activity light not lit after access");
  a_lamp_dark_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    left_r == 32'h0000_0000 && !trigger |=> !lamp_r)
    else $error("activity light lit while idle");

endmodule : activity_light

// [relay_matrix_control_bank.sv]
// relay matrix control bank: backplane slave, configuration registers and
// eight relay driver words, with forwarding to the expansion board
// assumes all backplane pins, switches and jumpers are asynchronous
`timescale 1ns/100ps
`include "relay_bank_regs.svh"
module relay_matrix_control_bank #(
  parameter int unsigned WORDS      = 8,
  parameter logic [15:0] ID_WORD    = 16'hcabc, // arbitrary value
  parameter logic [15:0] DEVTYPE    = 16'hf123, // arbitrary value
  parameter bit          MEM_A32    = 1'b0,
  parameter int unsigned LED_CYCLES = `BUS_LED_CYCLES
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // backplane cycle
  input  wire logic               as_n,
  input  wire logic [1:0]         ds_n,
  input  wire logic               write_n,
  input  wire logic [5:0]         am,
  input  wire logic [31:1]        addr,
  input  wire logic [15:0]        data_i,
  output logic      [15:0]        data_o,
  output logic                    data_oe,
  output logic                    dtack_n_o,
  output logic                    dtack_oe,
  // switches and jumpers
  input  wire logic [7:0]         la_switch,
  input  wire logic [1:0]         matrix_jumper,
  // expansion board buffers
  input  wire logic               exp_present,
  input  wire logic [15:0]        exp_rdata,
  output logic                    exp_sel_r,
  output logic                    exp_we_r,
  output logic [1:0]              exp_be_r,
  output logic [3:0]              exp_index_r,
  output logic [15:0]             exp_wdata_r,
  // relays
  input  wire logic [WORDS*16-1:0] coil_level,
  output logic      [WORDS*16-1:0] relay_coil,
  // indicators and settings
  output logic [2:0]              irq_level_r,
  output logic [4:0]              matrix_mode_r,
  output logic                    bus_light,
  output logic                    power_indicator_r
);

  localparam int unsigned SW = 84;

  relay_bank_pkg::bus_state_type st_r;
  logic [SW-1:0] pin_meta_r;
  logic [SW-1:0] pin_r;
  logic          s_as_n;
  logic [1:0]    s_ds_n;
  logic          s_write_n;
  logic [5:0]    s_am;
  logic [31:1]   s_addr;
  logic [15:0]   s_data;
  logic [7:0]    s_la;
  logic [1:0]    s_jumper;
  logic          s_exp;
  logic [15:0]   s_exp_rdata;
  logic [1:0]    strap_cnt_r;
  logic          strap_done_r;
  logic          fixed_address_setup_r;
  logic          assigned_address_setup;
  logic [7:0]    la_r;
  logic [15:0]   ctrl_r;
  logic [15:0]   mem_base_r;
  logic          am_a16;
  logic          am_a24;
  logic          am_a32;
  logic          hit_cfg;
  logic          hit_mem;
  logic [7:0]    ofs;
  logic          hit_relay;
  logic          hit_exp;
  logic          hit_local;
  logic          rd_req;
  logic          wr_req;
  logic [1:0]    be;
  logic [2:0]    word_idx;
  logic [2:0]    exp_cnt_r;
  logic [15:0]   rd_mux;
  logic [WORDS-1:0]    word_wr;
  logic [WORDS*16-1:0] coil_seen;
  logic          access_pulse;

  // every backplane and board pin passes two flops before use
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_r <= '1;
      pin_r      <= '1;
    end else begin
      pin_meta_r <= {as_n, ds_n, write_n, am, addr, data_i,
                     la_switch, matrix_jumper, exp_present, exp_rdata};
      pin_r      <= pin_meta_r;
    end
  end

  assign {s_as_n, s_ds_n, s_write_n, s_am, s_addr, s_data,
          s_la, s_jumper, s_exp, s_exp_rdata} = pin_r;

  // switches are caught once the synchroniser has filled after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r  <= strap_cnt_r + 2'h1;
      strap_done_r <= (strap_cnt_r == 2'h2);
    end
  end

  assign assigned_address_setup = !fixed_address_setup_r;

  // logical address: fixed by switches, or handed over by the manager
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      la_r                  <= `LA_DYNAMIC;
      fixed_address_setup_r <= 1'b0;
    end else if (!strap_done_r) begin
      la_r                  <= s_la;
      fixed_address_setup_r <= (s_la != `LA_DYNAMIC) && (s_la != `LA_NONE);
    end else if (st_r == relay_bank_pkg::st_decode && hit_cfg && wr_req &&
                 ofs == `OFS_ID && assigned_address_setup && be[0]) begin
      la_r <= s_data[7:0];
    end
  end

  // address modifier classes
  always_comb begin
    am_a16 = (s_am == 6'h29) || (s_am == 6'h2d);
    am_a24 = (s_am == 6'h39) || (s_am == 6'h3d) || (s_am == 6'h3a) || (s_am == 6'h3e);
    am_a32 = (s_am == 6'h09) || (s_am == 6'h0d) || (s_am == 6'h0a) || (s_am == 6'h0e);
  end

  assign be     = ~s_ds_n;
  assign rd_req = s_write_n;
  assign wr_req = !s_write_n;

  // window decode: configuration space in A16, relay words in A24 or A32
  always_comb begin
    hit_cfg = 1'b0;
    hit_mem = 1'b0;
    ofs     = 8'h00;
    if (am_a16 && s_addr[15:14] == `A16_CFG_TOP && s_addr[13:6] == la_r) begin
      hit_cfg = 1'b1;
      ofs     = {2'h0, s_addr[5:1], 1'b0};
    end else if (!MEM_A32 && am_a24 && ctrl_r[`CTRL_MEM_EN_BIT] &&
                 s_addr[23:8] == mem_base_r) begin
      hit_mem = 1'b1;
      ofs     = {s_addr[7:1], 1'b0};
    end else if (MEM_A32 && am_a32 && ctrl_r[`CTRL_MEM_EN_BIT] &&
                 s_addr[31:16] == mem_base_r && s_addr[15:8] == 8'h00) begin
      hit_mem = 1'b1;
      ofs     = {s_addr[7:1], 1'b0};
    end
  end

  always_comb begin
    hit_relay = hit_mem && ofs >= `OFS_RELAY_FIRST && ofs <= `OFS_RELAY_LAST;
    hit_exp   = hit_mem && s_exp && ofs >= `OFS_EXP_FIRST && ofs <= `OFS_EXP_LAST;
    hit_local = hit_cfg && (ofs == `OFS_ID || ofs == `OFS_DEVTYPE || ofs == `OFS_CTRL ||
                            ofs == `OFS_MEM_BASE || ofs == `OFS_IRQ_LEVEL);
    word_idx  = ofs[3:1];
  end

  // bus cycle sequencer: acknowledge mapped accesses, stay silent otherwise
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= relay_bank_pkg::st_idle;
    end else begin
      case (st_r)
        relay_bank_pkg::st_idle: begin
          if (strap_done_r && !s_as_n && s_ds_n != 2'h3) st_r <= relay_bank_pkg::st_decode;
        end
        relay_bank_pkg::st_decode: begin
          if (hit_exp) st_r <= relay_bank_pkg::st_exp;
          else if (hit_relay || hit_local) st_r <= relay_bank_pkg::st_ack;
          else st_r <= relay_bank_pkg::st_wait;
        end
        relay_bank_pkg::st_exp: begin
          if (exp_cnt_r == 3'h0) st_r <= relay_bank_pkg::st_ack;
        end
        relay_bank_pkg::st_ack: begin
          if (s_ds_n == 2'h3) st_r <= relay_bank_pkg::st_idle;
        end
        relay_bank_pkg::st_wait: begin
          if (s_ds_n == 2'h3) st_r <= relay_bank_pkg::st_idle;
        end
        default: st_r <= relay_bank_pkg::st_idle;
      endcase
    end
  end

  // expansion board access through the main-board buffers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      exp_sel_r   <= 1'b0;
      exp_we_r    <= 1'b0;
      exp_be_r    <= 2'h0;
      exp_index_r <= 4'h0;
      exp_wdata_r <= 16'h0000;
      exp_cnt_r   <= 3'h0;
    end else if (st_r == relay_bank_pkg::st_decode && hit_exp) begin
      exp_sel_r   <= 1'b1;
      exp_we_r    <= wr_req;
      exp_be_r    <= be;
      exp_index_r <= {1'b1, word_idx};
      exp_wdata_r <= s_data;
      exp_cnt_r   <= 3'(`EXP_WAIT_CYCLES - 1);
    end else if (st_r == relay_bank_pkg::st_exp && exp_cnt_r != 3'h0) begin
      exp_cnt_r <= exp_cnt_r - 3'h1;
    end else begin
      exp_sel_r <= 1'b0;
      exp_we_r  <= 1'b0;
    end
  end

  // control, memory base and interrupt level registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r      <= `CTRL_RST;
      mem_base_r  <= `MEM_BASE_RST;
      irq_level_r <= `IRQ_LEVEL_RST;
    end else if (st_r == relay_bank_pkg::st_decode && hit_cfg && wr_req) begin
      if (ofs == `OFS_CTRL) begin
        if (be[0]) ctrl_r[7:0] <= s_data[7:0];
        if (be[1]) ctrl_r[15:8] <= s_data[15:8];
      end else if (ofs == `OFS_MEM_BASE) begin
        if (be[0]) mem_base_r[7:0] <= s_data[7:0];
        if (be[1]) mem_base_r[15:8] <= s_data[15:8];
      end else if (ofs == `OFS_IRQ_LEVEL && be[0]) begin
        irq_level_r <= s_data[2:0];
      end
    end
  end

  // matrix grouping from the jumpers and the expansion board
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      matrix_mode_r <= relay_bank_pkg::mode_single_2x64;
    end else if (!s_exp) begin
      matrix_mode_r <= s_jumper[0] ? relay_bank_pkg::mode_dual_2x32
                                   : relay_bank_pkg::mode_single_2x64;
    end else if (s_jumper[0]) begin
      matrix_mode_r <= relay_bank_pkg::mode_quad_2x32;
    end else if (s_jumper[1]) begin
      matrix_mode_r <= relay_bank_pkg::mode_dual_2x64;
    end else begin
      matrix_mode_r <= relay_bank_pkg::mode_single_2x128;
    end
  end

  // words 40h-46h: A/B pins 1-32; from 48h C/D pins 1-32 or A/B pins 33-64
  generate
    for (genvar w = 0; w < WORDS; w++) begin : g_word
      assign word_wr[w] = st_r == relay_bank_pkg::st_decode && hit_relay && wr_req &&
                          word_idx == 3'(w);
      relay_driver_word u_word (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .wr_en        (word_wr[w]),
        .wr_be        (be),
        .wr_data      (s_data),
        .clear        (ctrl_r[`CTRL_CLEAR_BIT]),
        .coil_level   (coil_level[w*16 +: 16]),
        .coil_drive_r (relay_coil[w*16 +: 16]),
        .coil_seen_r  (coil_seen[w*16 +: 16])
      );
    end
  endgenerate

  // read data: register contents or sampled coil level per control bit
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_relay) begin
      rd_mux = ctrl_r[`CTRL_COIL_RD_BIT] ? coil_seen[word_idx*16 +: 16]
                                         : relay_coil[word_idx*16 +: 16];
    end else if (ofs == `OFS_ID) begin
      rd_mux = ID_WORD;
    end else if (ofs == `OFS_DEVTYPE) begin
      rd_mux = DEVTYPE;
    end else if (ofs == `OFS_CTRL) begin
      rd_mux = ctrl_r;
      rd_mux[12:`STAT_MODE_LSB] = matrix_mode_r;
      rd_mux[`STAT_FIXED_BIT]   = fixed_address_setup_r;
      rd_mux[`STAT_EXP_BIT]     = s_exp;
    end else if (ofs == `OFS_MEM_BASE) begin
      rd_mux = mem_base_r;
    end else if (ofs == `OFS_IRQ_LEVEL) begin
      rd_mux = {13'h0, irq_level_r};
    end
  end

  // bus drivers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_o    <= 16'h0000;
      data_oe   <= 1'b0;
      dtack_n_o <= 1'b1;
      dtack_oe  <= 1'b0;
    end else if (st_r == relay_bank_pkg::st_decode && (hit_relay || hit_local)) begin
      data_o    <= rd_mux;
      data_oe   <= rd_req;
      dtack_n_o <= 1'b0;
      dtack_oe  <= 1'b1;
    end else if (st_r == relay_bank_pkg::st_exp && exp_cnt_r == 3'h0) begin
      data_o    <= s_exp_rdata;
      data_oe   <= !exp_we_r;
      dtack_n_o <= 1'b0;
      dtack_oe  <= 1'b1;
    end else if (st_r == relay_bank_pkg::st_ack && s_ds_n == 2'h3) begin
      data_oe   <= 1'b0;
      dtack_n_o <= 1'b1;
      dtack_oe  <= 1'b0;
    end
  end

  assign access_pulse = st_r == relay_bank_pkg::st_decode && (hit_cfg || hit_mem);

  activity_light #(
    .ON_CYCLES (LED_CYCLES)
  ) u_light (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .trigger (access_pulse),
    .lamp_r  (bus_light)
  );

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_indicator_r <= 1'b0;
    end else begin
      power_indicator_r <= 1'b1;
    end
  end

  sequence s_mapped_hit;
    st_r == relay_bank_pkg::st_decode && (hit_relay || hit_local);
  endsequence
  sequence s_acked;
    dtack_oe && !dtack_n_o;
  endsequence

  a_ack_mapped: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_mapped_hit |=> s_acked)
    else $error("mapped access not acknowledged");
  a_unmapped_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_r == relay_bank_pkg::st_decode && !hit_exp && !hit_relay && !hit_local
    |=> !dtack_oe [*2])
    else $error("unmapped access acknowledged");
  a_relays_open_reset: assert property (@(posedge ref_clk)
    $rose(reset_n) |-> relay_coil == '0)
    else $error("relays not open after reset");
  a_irq_none_reset: assert property (@(posedge ref_clk)
    $rose(reset_n) |-> irq_level_r == 3'h0)
    else $error("interrupt level not cleared at reset");
  a_irq_level_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_r == relay_bank_pkg::st_decode && hit_cfg && wr_req && ofs == `OFS_IRQ_LEVEL && be[0]
    |=> irq_level_r == $past(s_data[2:0]))
    else $error("interrupt level not taken from 3eh write");
  a_coil_readback: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_mapped_hit and (hit_relay && rd_req && ctrl_r[`CTRL_COIL_RD_BIT])
    |=> data_oe && data_o == $past(coil_seen[word_idx*16 +: 16]))
    else $error("coil level not returned on read");
  a_fixed_la_locked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    strap_done_r && fixed_address_setup_r |=> $stable(la_r))
    else $error("fixed logical address changed");
  a_word_independent: assert property (@(posedge ref_clk) disable iff (!reset_n)
    word_wr == '0 && !ctrl_r[`CTRL_CLEAR_BIT] |=> $stable(relay_coil))
    else $error("relay changed without a write");

endmodule : relay_matrix_control_bank

// [coil_sense_model.sv]
// relay coils and their level sensors as seen from the bank's coil pins
// assumes relay_coil comes straight from the bank; fault inverts a sense line
`timescale 1ns/100ps
module coil_sense_model #(
  parameter int unsigned BITS = 128
) (
  // coil drive and injected faults
  input  wire logic [BITS-1:0] relay_coil,
  input  wire logic [BITS-1:0] fault,
  // sensed level
  output logic      [BITS-1:0] coil_level
);
  // a healthy coil reads back its drive, a broken one the inverse
  assign coil_level = relay_coil ^ fault;
endmodule : coil_sense_model

// [relay_matrix_control_bank_tb.sv]
// self-checking bench for the relay bank, driving backplane cycles
// assumes switches 01h; jumpers and expansion board are driven by the bench
`timescale 1ns/100ps
module relay_matrix_control_bank_tb;
  localparam logic [31:0] CFG = 32'h0000c040;
  localparam logic [31:0] MEM = 32'h00120000;
  localparam logic [5:0]  A16 = 6'h29;
  localparam logic [5:0]  A24 = 6'h39;
  localparam logic [15:0] PAT [8] = '{16'h0001, 16'h8000, 16'h00ff, 16'hff00,
                                      16'h5a5a, 16'ha5a5, 16'h1234, 16'hffff};
  logic         ref_clk, reset_n, as_n, write_n, ack;
  logic [1:0]   ds_n;
  logic [5:0]   am;
  logic [31:0]  a;
  logic [15:0]  data_i, data_o, rd;
  logic         data_oe, dtack_n_o, dtack_oe, bus_light, power_indicator_r;
  logic         exp_present, exp_sel_r, exp_we_r, oe;
  logic [1:0]   jumper, exp_be_r;
  logic [3:0]   exp_index_r;
  logic [15:0]  exp_rdata, exp_wdata_r;
  logic [7:0]   la_switch;
  logic [127:0] coil_level, relay_coil, fault;
  logic [2:0]   irq_level_r;
  logic [4:0]   matrix_mode_r;
  int           num_errors, total_checks, cycles, exp_wr_cycles;

  relay_matrix_control_bank #(.LED_CYCLES(20)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .as_n(as_n), .ds_n(ds_n), .write_n(write_n),
    .am(am), .addr(a[31:1]), .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
    .dtack_n_o(dtack_n_o), .dtack_oe(dtack_oe), .la_switch(la_switch),
    .matrix_jumper(jumper), .exp_present(exp_present), .exp_rdata(exp_rdata),
    .exp_sel_r(exp_sel_r), .exp_we_r(exp_we_r), .exp_be_r(exp_be_r),
    .exp_index_r(exp_index_r), .exp_wdata_r(exp_wdata_r), .coil_level(coil_level),
    .relay_coil(relay_coil), .irq_level_r(irq_level_r), .matrix_mode_r(matrix_mode_r),
    .bus_light(bus_light), .power_indicator_r(power_indicator_r));

  coil_sense_model u_coils (.relay_coil(relay_coil), .fault(fault), .coil_level(coil_level));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // one backplane cycle; strobes held until dtack is sampled or 40 clocks pass, then released
  task automatic cycle(input logic [5:0] m, input logic [31:0] adr, input logic wr,
                       input logic [15:0] wd);
    int n;
    @(posedge ref_clk);
    #2;
    am = m;
    a = adr;
    write_n = ~wr;
    data_i = wd;
    as_n = 1'b0;
    ds_n = 2'h0;
    n = 0;
    ack = 1'b0;
    oe = 1'b0;
    while (n < 40 && !ack) begin
      @(posedge ref_clk);
      if (dtack_oe === 1'b1 && dtack_n_o === 1'b0) begin
        ack = 1'b1;
        rd = data_o;
        oe = data_oe;
      end
      n++;
    end
    #2;
    as_n = 1'b1;
    ds_n = 2'h3;
    repeat (4) @(posedge ref_clk);
  endtask : cycle

  task automatic wr16(input logic [5:0] m, input logic [31:0] adr, input logic [15:0] wd);
    cycle(m, adr, 1'b1, wd);
    check({14'h0, oe, ack}, 16'h0001, "write acknowledged");
  endtask : wr16

  task automatic rd16(input logic [5:0] m, input logic [31:0] adr, input logic [15:0] mask,
                      input logic [15:0] exp, input string what);
    cycle(m, adr, 1'b0, 16'h0000);
    check({14'h0, oe, ack}, 16'h0003, "read acknowledged");
    check(rd & mask, exp, what);
  endtask : rd16

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (exp_sel_r === 1'b1 && exp_we_r === 1'b1) exp_wr_cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("mismatch at %0t: run timed out", $time);
      close_out();
    end
  end

  initial begin
    reset_n = 1'b0;
    as_n = 1'b1;
    ds_n = 2'h3;
    write_n = 1'b1;
    am = 6'h00;
    a = 32'h0;
    data_i = 16'h0000;
    la_switch = 8'h01;
    jumper = 2'h0;
    exp_present = 1'b0;
    exp_rdata = 16'h0000;
    fault = '0;
    repeat (20) @(posedge ref_clk);
    check({15'h0, |relay_coil}, 16'h0000, "coils open in reset");
    check({13'h0, irq_level_r}, 16'h0000, "no interrupt level");
    check({14'h0, power_indicator_r, bus_light}, 16'h0000, "light and power dark");
    check({11'h0, matrix_mode_r}, 16'h0001, "single 2x64 mode");
    #2;
    reset_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    $display("test reset done");
    wr16(A16, CFG | 32'h04, 16'h8000);
    wr16(A16, CFG | 32'h06, 16'h1200);
    check({15'h0, bus_light}, 16'h0001, "light lit on access");
    wr16(A16, CFG | 32'h3e, 16'h0005);
    check({13'h0, irq_level_r}, 16'h0005, "interrupt level");
    rd16(A16, CFG | 32'h3e, 16'h0007, 16'h0005, "level read back");
    rd16(A16, CFG | 32'h04, 16'h1f0c, 16'h0108, "fixed flag, 2x64, no board");
    cycle(A16, 32'h0000c080, 1'b0, 16'h0000);
    check({15'h0, ack}, 16'h0000, "other address ignored");
    $display("test config done");
    for (int i = 0; i < 8; i++) wr16(A24, MEM | (32'h40 + 2 * i), PAT[i]);
    for (int i = 0; i < 8; i++) check(relay_coil[i*16 +: 16], PAT[i], "coil drive");
    for (int i = 0; i < 8; i++) rd16(A24, MEM | (32'h40 + 2 * i), 16'hffff, PAT[i], "word");
    $display("test relay words done");
    cycle(A24, MEM | 32'h60, 1'b0, 16'h0000);
    check({15'h0, ack}, 16'h0000, "unmapped offset");
    cycle(A24, MEM | 32'h50, 1'b1, 16'h0001);
    check({15'h0, ack}, 16'h0000, "expansion absent");
    $display("test refused done");
    #2;
    fault[3] = 1'b1;
    wr16(A16, CFG | 32'h04, 16'h8002);
    rd16(A24, MEM | 32'h40, 16'hffff, PAT[0] ^ 16'h0008, "coil level read");
    wr16(A16, CFG | 32'h04, 16'h8000);
    rd16(A24, MEM | 32'h40, 16'hffff, PAT[0], "register read");
    $display("test read back done");
    wr16(A16, CFG | 32'h04, 16'h8001);
    check({15'h0, |relay_coil}, 16'h0000, "clear opens all");
    repeat (40) @(posedge ref_clk);
    check({15'h0, bus_light}, 16'h0000, "light dark when idle");
    $display("test clear and light done");
    #2;
    jumper = 2'h1;
    rd16(A16, CFG | 32'h04, 16'h1f04, 16'h0200, "dual 2x32 mode");
    #2;
    exp_present = 1'b1;
    exp_rdata = 16'h3c3c;
    rd16(A16, CFG | 32'h04, 16'h1f04, 16'h1004, "quad 2x32 mode");
    #2;
    jumper = 2'h2;
    rd16(A16, CFG | 32'h04, 16'h1f04, 16'h0804, "dual 2x64 mode");
    #2;
    jumper = 2'h0;
    rd16(A16, CFG | 32'h04, 16'h1f04, 16'h0404, "single 2x128 mode");
    wr16(A24, MEM | 32'h52, 16'h1234);
    check(exp_wdata_r, 16'h1234, "expansion write data");
    check({10'h0, exp_be_r, exp_index_r}, 16'h0039, "expansion lanes and word");
    rd16(A24, MEM | 32'h50, 16'hffff, 16'h3c3c, "expansion read");
    check(exp_wr_cycles[15:0], 16'h0004, "expansion write strobe length");
    $display("test modes and expansion done");
    wr16(A16, CFG | 32'h04, 16'h8000);
    wr16(A24, MEM | 32'h4e, 16'hffff);
    check(relay_coil[127:112], 16'hffff, "whole word closed");
    #2;
    reset_n = 1'b0;
    @(posedge ref_clk);
    check({14'h0, power_indicator_r, |relay_coil}, 16'h0000, "reset opens relays");
    #2;
    reset_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    check({15'h0, power_indicator_r}, 16'h0001, "power lit after reset");
    rd16(A16, CFG | 32'h3e, 16'h0007, 16'h0000, "no level after reset");
    $display("test second reset done");
    close_out();
  end
endmodule : relay_matrix_control_bank_tb
